// >>> dpscu_checker.sv
// Port-level assertions for the serial command unit
`timescale 1ns/100ps
module dpscu_checker
    import dpscu_pkg::*;
#(
    parameter int NV_CYCLES = 20
) (
    input logic CLK_SYS,
    input logic RSTN,
    input logic SPI_CLK_PIN,
    input logic SERIAL_IN_PIN,
    input logic CHIP_SELECT_PIN_N,
    input logic WRITE_PROTECT_PIN_N,
    input logic PRESET_STROBE_PIN_N,
    input logic SERIAL_OUT_PIN_O,
    input logic SERIAL_OUT_PIN_OE_N,
    input logic READY,
    input logic [VAL_W-1:0] WIPER0_SETTING,
    input logic [VAL_W-1:0] WIPER1_SETTING
);
    // ==========
    // Busy length counter
    typedef struct packed {
        logic [19:0] cnt;
        logic prev;
        logic armed;
    } dpscu_chk_t;
    dpscu_chk_t st_r;
    dpscu_chk_t st_nxt;

    // Count low cycles of ready, armed only by a real fall
    always_comb begin
        st_nxt.cnt = READY ? 20'h0 : st_r.cnt + 20'h1;
        st_nxt.prev = READY;
        st_nxt.armed = READY ? 1'b0 : (st_r.armed | st_r.prev);
    end

    // Register the counter state
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    // ==========
    // Assertions
    out_release_a: assert property (CHIP_SELECT_PIN_N [*3] |-> SERIAL_OUT_PIN_OE_N)
        else $error("serial out driven while deselected");
    hold_in_frame_a: assert property (!CHIP_SELECT_PIN_N [*6] |->
        $stable(WIPER0_SETTING) && $stable(WIPER1_SETTING))
        else $error("wiper moved during shifting");
    exec_on_rise_a: assert property ($changed(WIPER0_SETTING) ||
        $changed(WIPER1_SETTING) |-> $past(CHIP_SELECT_PIN_N, 2))
        else $error("wiper moved without select high");
    ready_fall_a: assert property ($fell(READY) |->
        CHIP_SELECT_PIN_N && $past(CHIP_SELECT_PIN_N, 2))
        else $error("ready fell inside a frame");
    busy_len_a: assert property ($rose(READY) && st_r.armed |->
        st_r.cnt >= NV_CYCLES - 1 && st_r.cnt <= NV_CYCLES + 1)
        else $error("busy period has wrong length");
    ready_min_a: assert property ($fell(READY) |=> !READY [*8])
        else $error("busy period too short");
    busy_lock_a: assert property (!READY && !$past(READY) |->
        $stable(WIPER0_SETTING) && $stable(WIPER1_SETTING) && SERIAL_OUT_PIN_OE_N)
        else $error("activity while busy");
    reset_load_a: assert property ($rose(RSTN) |-> ##[1:3] (READY &&
        WIPER0_SETTING == VAL_FACTORY && WIPER1_SETTING == VAL_FACTORY))
        else $error("no recall after reset");

    // Main scenarios reached
    cover property ($fell(READY));
    cover property ($changed(WIPER1_SETTING));
    cover property (!SERIAL_OUT_PIN_OE_N);
endmodule : dpscu_checker

bind dpscu_top dpscu_checker #(.NV_CYCLES(NV_CYCLES)) u_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SPI_CLK_PIN(SPI_CLK_PIN),
    .SERIAL_IN_PIN(SERIAL_IN_PIN), .CHIP_SELECT_PIN_N(CHIP_SELECT_PIN_N),
    .WRITE_PROTECT_PIN_N(WRITE_PROTECT_PIN_N), .PRESET_STROBE_PIN_N(PRESET_STROBE_PIN_N),
    .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O), .SERIAL_OUT_PIN_OE_N(SERIAL_OUT_PIN_OE_N),
    .READY(READY), .WIPER0_SETTING(WIPER0_SETTING), .WIPER1_SETTING(WIPER1_SETTING)
);

// >>> dpscu_pkg.sv
// Shared constants, command codes and state codes of the serial command unit
package dpscu_pkg;

    // =========================================================
    // Serial word layout
    localparam int WORD_BITS = 24;
    localparam logic [4:0] WORD_BITS_CNT = 5'h18;
    localparam int CNT_W = 5;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 9;
    localparam int DATA_LSB = 0;
    localparam int CMD_W = 4;
    localparam int ADDR_W = 4;
    localparam int VAL_W = 10;
    localparam int CH_NUM = 2;
    localparam logic [3:0] ADDR_RECALL_ALL = 4'h0;

    // =========================================================
    // Setting values
    localparam logic [9:0] VAL_FACTORY = 10'h200;
    localparam logic [9:0] VAL_ONES = 10'h3ff;
    localparam logic [9:0] VAL_ZERO = 10'h000;

    // =========================================================
    // Timing
    localparam int CLK_SYS_PERIOD_NS = 40;
    localparam int NV_WRITE_TIME_NS = 20200000;
    localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
    localparam int NV_CNT_W = 20;

    // =========================================================
    // Synchroniser bit positions and idle levels
    localparam int SYNC_SCLK = 0;
    localparam int SYNC_SDI = 1;
    localparam int SYNC_CSN = 2;
    localparam int SYNC_WPN = 3;
    localparam int SYNC_PRN = 4;
    localparam int SYNC_W = 5;
    localparam logic [4:0] SYNC_RST = 5'h1c;

    // =========================================================
    // Commands and states
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_NV_TO_WIPER = 4'h1,
        CMD_SAVE_WIPER = 4'h2,
        CMD_NV_WRITE = 4'h3,
        CMD_ROR_ONE = 4'h4,
        CMD_ROR_ALL = 4'h5,
        CMD_DEC_ONE = 4'h6,
        CMD_DEC_ALL = 4'h7,
        CMD_RECALL_ALL = 4'h8,
        CMD_READ_NV = 4'h9,
        CMD_READ_WIPER = 4'ha,
        CMD_LOAD_WIPER = 4'hb,
        CMD_SHL_ONE = 4'hc,
        CMD_SHL_ALL = 4'hd,
        CMD_INC_ONE = 4'he,
        CMD_INC_ALL = 4'hf
    } dpscu_cmd_t;

    typedef enum logic [1:0] {
        ST_RECALL = 2'b00,
        ST_IDLE = 2'b01,
        ST_NV_BUSY = 2'b10
    } dpscu_state_t;

endpackage : dpscu_pkg

// >>> dpscu_spi_master.sv
// Host master model that clocks serial words into the unit
`timescale 1ns/100ps
module dpscu_spi_master (
    output logic sclk,
    output logic serial_in_pin,
    output logic cs_n,
    input wire logic serial_out_pin
);
    // Idle link: select high, clock at rest
    initial begin
        sclk = 1'b1;
        serial_in_pin = 1'b0;
        cs_n = 1'b1;
    end

    task automatic xfer(input logic [23:0] w, input int n, input logic cpol,
        output logic [23:0] r);
        r = 24'h0;
        sclk = cpol;
        #320 cs_n = 1'b0;
        #160;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            serial_in_pin = w[23 - (i % 24)];
            #160 sclk = 1'b1;
            r = {r[22:0], serial_out_pin};
            #160;
        end
        sclk = cpol;
        #160 cs_n = 1'b1;
        // Released data line shows no stale bit
        serial_in_pin = ~serial_in_pin;
        #320;
    endtask : xfer
endmodule : dpscu_spi_master

// >>> dpscu_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/100ps
module dpscu_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } dpscu_sync_t;

    dpscu_sync_t s_r;
    dpscu_sync_t s_nxt;

    // First stage is only read by the second stage
    always_comb begin
        s_nxt.meta = d;
        s_nxt.stab = s_r.meta;
    end

    // Registers reset to the idle levels of the pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= {RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stab;
endmodule : dpscu_sync

// >>> dpscu_tb_top.sv
// Self-checking bench of the serial command unit
`timescale 1ns/100ps
module dpscu_tb_top;
    import dpscu_pkg::*;
    localparam int NVC = 400;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1;
    logic pr_n = 1'b1;
    logic sclk, serial_in_pin, cs_n, so, oe_n, rdy;
    logic [9:0] w0, w1, v;
    wire sdo_pin = oe_n ? 1'b1 : so;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'h70cda00e;
    logic [9:0] ew [2];
    logic [9:0] env [2];
    logic [23:0] exp_nx;
    logic exp_ok = 1'b0;
    logic [7:0] rep = 8'h0;
    logic rep_ok = 1'b0;
    logic [3:0] steps [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};

    // 25 MHz system clock
    initial begin
        forever #20 clk = ~clk;
    end

    dpscu_top #(.NV_CYCLES(NVC)) dut (
        .CLK_SYS(clk), .RSTN(rstn), .SPI_CLK_PIN(sclk), .SERIAL_IN_PIN(serial_in_pin),
        .CHIP_SELECT_PIN_N(cs_n), .WRITE_PROTECT_PIN_N(wp_n),
        .PRESET_STROBE_PIN_N(pr_n), .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE_N(oe_n),
        .READY(rdy), .WIPER0_SETTING(w0), .WIPER1_SETTING(w1)
    );
    dpscu_spi_master host (.sclk(sclk), .serial_in_pin(serial_in_pin), .cs_n(cs_n), .serial_out_pin(sdo_pin));

    // ==========
    // Compare and report
    task automatic chk_val(input logic [23:0] g, input logic [23:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_val

    task automatic chk_flag(input logic g, input logic e);
        chk_val({23'h0, g}, {23'h0, e});
    endtask : chk_flag

    task automatic finish_test();
        $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // ==========
    // Expected behaviour
    function automatic logic [9:0] step(input logic [3:0] c, input logic [9:0] x);
        case (c)
            4'h4, 4'h5: return {x[0], x[9:1]};
            4'h6, 4'h7: return (x == VAL_ZERO) ? x : x - 10'h1;
            4'hc, 4'hd: return x[9] ? VAL_ONES : {x[8:0], 1'b0};
            default: return (x == VAL_ONES) ? x : x + 10'h1;
        endcase
    endfunction : step

    task automatic model(input logic [3:0] c, input logic [3:0] a, input logic [9:0] d);
        logic one;
        one = (a < 4'h2);
        case (c)
            4'h1: if (one) ew[a[0]] = env[a[0]];
            4'h2: if (one && wp_n) env[a[0]] = ew[a[0]];
            4'h3: if (one && wp_n) env[a[0]] = d;
            4'h8: if (a == ADDR_RECALL_ALL) ew = env;
            4'hb: if (one) ew[a[0]] = d;
            4'h4, 4'h6, 4'hc, 4'he: if (one) ew[a[0]] = step(c, ew[a[0]]);
            4'h5, 4'h7, 4'hd, 4'hf: foreach (ew[i]) ew[i] = step(c, ew[i]);
            default: ;
        endcase
    endtask : model

    // One transfer of n bits; busy marks a frame sent during a store update
    task automatic frame(input logic [23:0] w, input int n = 24, input logic busy = 1'b0);
        logic [23:0] r;
        logic [3:0] c;
        logic [3:0] a;
        c = (n == 0) ? rep[7:4] : w[23:20];
        a = (n == 0) ? rep[3:0] : w[19:16];
        host.xfer(w, n, 1'($random(seed)), r);
        if (n == 24 && exp_ok && !busy) chk_val(r, exp_nx);
        repeat (8) @(negedge clk);
        if (n != 0 && n != 24) exp_ok = 1'b0;
        if (!busy && (n == 24 || (n == 0 && rep_ok))) model(c, a, w[9:0]);
        if (!busy && n == 24) begin
            exp_nx = w;
            exp_ok = 1'b1;
            if (c == 4'h9) exp_nx[9:0] = (a < 4'h2) ? env[a[0]] : VAL_ZERO;
            if (c == 4'ha) exp_nx[9:0] = (a < 4'h2) ? ew[a[0]] : VAL_ZERO;
            rep = {c, a};
            rep_ok = c[2];
        end
        chk_val({4'h0, w1, w0}, {4'h0, ew[1], ew[0]});
    endtask : frame

    task automatic wait_ready();
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 2 * NVC) begin
            @(negedge clk);
            k++;
        end
        if (rdy !== 1'b1) begin
            mismatches++;
            finish_test();
        end
    endtask : wait_ready

    // ==========
    // Main sequence
    initial begin
        ew = '{VAL_FACTORY, VAL_FACTORY};
        env = ew;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk_val({4'h0, w1, w0}, {4'h0, ew[1], ew[0]});
        chk_flag(rdy, 1'b1);
        for (int a = 0; a < 3; a++) begin
            frame({4'hb, 4'(a), 6'h2a, 10'($random(seed))});
            frame({4'ha, 4'(a), 16'h5555});
            frame({4'h9, 4'(a), 16'h0});
        end
        frame({4'h3, 4'h1, 6'h0, 10'($random(seed))});
        chk_flag(rdy, 1'b0);
        frame({4'hb, 4'h1, 16'h0155}, 24, 1'b1);
        chk_flag(rdy, 1'b0);
        wait_ready();
        frame({4'h9, 4'h1, 16'h0});
        frame({4'h1, 4'h1, 16'h0});
        frame({4'hb, 4'h0, 6'h0, 10'($random(seed))});
        frame({4'h2, 4'h0, 16'h0});
        wait_ready();
        frame({4'h9, 4'h0, 16'h0});
        wp_n = 1'b0;
        repeat (4) @(negedge clk);
        frame({4'h3, 4'h0, 6'h0, 10'($random(seed))});
        chk_flag(rdy, 1'b1);
        frame({4'h2, 4'h1, 16'h0});
        frame({4'h9, 4'h0, 16'h0});
        wp_n = 1'b1;
        foreach (steps[k]) begin
            for (int j = 0; j < 3; j++) begin
                v = (j == 0) ? VAL_ZERO : (j == 1) ? VAL_ONES : 10'($random(seed));
                frame({4'hb, 4'h0, 6'h0, v});
                frame({4'hb, 4'h1, 6'h0, ~v});
                frame({steps[k], 4'(j), 16'($random(seed))});
            end
        end
        frame({4'hb, 4'h1, 16'h03fd});
        frame({4'he, 4'h1, 16'h00ff});
        for (int i = 0; i < 3; i++) frame(24'h0, 0);
        frame({4'h7, 4'h0, 16'h0});
        frame(24'h0, 0);
        frame(24'h0);
        frame(24'h0, 0);
        frame({4'h8, 4'h1, 16'h0});
        frame({4'h8, 4'h0, 16'h0});
        frame({4'hb, 4'h0, 16'h0123}, 23);
        frame({4'hb, 4'h0, 16'h0123}, 25);
        frame({4'hb, 4'h0, 16'h0077});
        pr_n = 1'b0;
        ew = env;
        repeat (8) @(negedge clk);
        pr_n = 1'b1;
        chk_val({4'h0, w1, w0}, {4'h0, ew[1], ew[0]});
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        ew = '{VAL_FACTORY, VAL_FACTORY};
        env = ew;
        exp_ok = 1'b0;
        rep_ok = 1'b0;
        repeat (4) @(negedge clk);
        chk_val({4'h0, w1, w0}, {4'h0, ew[1], ew[0]});
        chk_flag(rdy, 1'b1);
        frame(24'h0);
        finish_test();
    end
endmodule : dpscu_tb_top

// >>> dpscu_top.sv
// Serial command unit of a dual 1024-step potentiometer with nonvolatile store
`timescale 1ns/100ps
module dpscu_top
    import dpscu_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic SPI_CLK_PIN,
    input wire logic SERIAL_IN_PIN,
    input wire logic CHIP_SELECT_PIN_N,
    input wire logic WRITE_PROTECT_PIN_N,
    input wire logic PRESET_STROBE_PIN_N,
    output logic SERIAL_OUT_PIN_O,
    output logic SERIAL_OUT_PIN_OE_N,
    output logic READY,
    output logic [VAL_W-1:0] WIPER0_SETTING,
    output logic [VAL_W-1:0] WIPER1_SETTING
);
    // =========================================================
    // State of the unit
    typedef struct packed {
        dpscu_state_t state;
        logic sclk_prev;
        logic csn_prev;
        logic prn_prev;
        logic [WORD_BITS-1:0] shift;
        logic [CNT_W-1:0] bit_cnt;
        logic sdo_bit;
        logic [CH_NUM-1:0][VAL_W-1:0] wiper;
        logic [CH_NUM-1:0][VAL_W-1:0] nv;
        logic rep_valid;
        dpscu_cmd_t rep_cmd;
        logic [ADDR_W-1:0] rep_addr;
        logic [NV_CNT_W-1:0] busy_cnt;
        logic ready;
    } dpscu_regs_t;

    localparam dpscu_regs_t REGS_RST = '{
        state: ST_RECALL,
        sclk_prev: 1'b0,
        csn_prev: 1'b1,
        prn_prev: 1'b1,
        shift: 24'h000000,
        bit_cnt: 5'h00,
        sdo_bit: 1'b1,
        wiper: {VAL_FACTORY, VAL_FACTORY},
        nv: {VAL_FACTORY, VAL_FACTORY},
        rep_valid: 1'b0,
        rep_cmd: CMD_NOP,
        rep_addr: 4'h0,
        busy_cnt: 20'h00000,
        ready: 1'b0
    };

    dpscu_regs_t r_r;
    dpscu_regs_t r_nxt;

    // =========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic s_sclk;
    logic s_sdi;
    logic s_csn;
    logic s_wpn;
    logic s_prn;

    // Group the asynchronous pins for the synchroniser
    assign pins_async[SYNC_SCLK] = SPI_CLK_PIN;
    assign pins_async[SYNC_SDI] = SERIAL_IN_PIN;
    assign pins_async[SYNC_CSN] = CHIP_SELECT_PIN_N;
    assign pins_async[SYNC_WPN] = WRITE_PROTECT_PIN_N;
    assign pins_async[SYNC_PRN] = PRESET_STROBE_PIN_N;

    dpscu_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d(pins_async),
        .q(pins_sync)
    );

    // Stable copies of the pins
    assign s_sclk = pins_sync[SYNC_SCLK];
    assign s_sdi = pins_sync[SYNC_SDI];
    assign s_csn = pins_sync[SYNC_CSN];
    assign s_wpn = pins_sync[SYNC_WPN];
    assign s_prn = pins_sync[SYNC_PRN];

    // =========================================================
    // Edge detection and command selection
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic take_word;
    logic take_repeat;
    logic exec;
    dpscu_cmd_t ex_cmd;
    logic [ADDR_W-1:0] ex_addr;
    logic [VAL_W-1:0] ex_data;
    logic ex_ok;
    logic ex_step;
    logic [CH_NUM-1:0][VAL_W-1:0] step_val;

    // Both supported modes sample on the rising clock edge
    // mode zero and three
    assign sclk_rise = s_sclk & ~r_r.sclk_prev;
    assign sclk_fall = ~s_sclk & r_r.sclk_prev;
    assign cs_fall = ~s_csn & r_r.csn_prev;
    // execute on rise, not while locked
    assign cs_rise = s_csn & ~r_r.csn_prev & (r_r.state == ST_IDLE);
    // exactly 24 bits form a word
    assign take_word = cs_rise & (r_r.bit_cnt == WORD_BITS_CNT);
    assign take_repeat = cs_rise & (r_r.bit_cnt == 5'h00) & r_r.rep_valid;
    assign exec = take_word | take_repeat;

    assign ex_cmd = take_word ? dpscu_cmd_t'(r_r.shift[CMD_MSB:CMD_LSB]) : r_r.rep_cmd;
    assign ex_addr = take_word ? r_r.shift[ADDR_MSB:ADDR_LSB] : r_r.rep_addr;
    assign ex_data = r_r.shift[DATA_MSB:DATA_LSB];
    // only channels zero and one exist
    assign ex_ok = (ex_addr < ADDR_W'(CH_NUM));
    // Stepping commands all carry bit two of the code
    assign ex_step = ex_cmd[2];

    // One stepping unit per channel
    for (genvar i = 0; i < CH_NUM; i++) begin : g_step
        dpscu_wiper_step u_step (
            .cmd(ex_cmd),
            .value(r_r.wiper[i]),
            .next_value(step_val[i])
        );
    end

    // =========================================================
    // Next-state logic
    always_comb begin
        r_nxt = r_r;
        r_nxt.sclk_prev = s_sclk;
        r_nxt.csn_prev = s_csn;
        r_nxt.prn_prev = s_prn;

        case (r_r.state)
            ST_RECALL: begin
                r_nxt.wiper = r_r.nv;
                r_nxt.ready = 1'b1;
                r_nxt.state = ST_IDLE;
            end
            ST_IDLE: begin
                // Preset strobe pin refreshes the wipers from the store
                if (r_r.prn_prev & ~s_prn) begin
                    r_nxt.wiper = r_r.nv;
                end
                if (cs_fall) begin
                    // First output bit is ready before the first rising edge
                    r_nxt.bit_cnt = 5'h00;
                    r_nxt.sdo_bit = r_r.shift[WORD_BITS-1];
                end else if (~s_csn) begin
                    if (sclk_rise) begin
                        r_nxt.shift = {r_r.shift[WORD_BITS-2:0], s_sdi};
                        if (r_r.bit_cnt != 5'h1f) begin
                            r_nxt.bit_cnt = CNT_W'(r_r.bit_cnt + 5'h01);
                        end
                    end
                    // previous word leaves on falling edges
                    if (sclk_fall) begin
                        r_nxt.sdo_bit = r_r.shift[WORD_BITS-1];
                    end
                end else begin
                    r_nxt.sdo_bit = 1'b1;
                end
                if (cs_rise) begin
                    r_nxt.bit_cnt = 5'h00;
                end
                if (take_word) begin
                    r_nxt.rep_valid = ex_step;
                    r_nxt.rep_cmd = ex_cmd;
                    r_nxt.rep_addr = ex_addr;
                end
                if (exec) begin
                    case (ex_cmd)
                        CMD_NOP: begin
                            r_nxt.rep_valid = 1'b0;
                        end
                        CMD_NV_TO_WIPER: begin
                            if (ex_ok) begin
                                r_nxt.wiper[ex_addr[0]] = r_r.nv[ex_addr[0]];
                            end
                        end
                        CMD_SAVE_WIPER: begin
                            if (ex_ok & s_wpn) begin
                                r_nxt.nv[ex_addr[0]] = r_r.wiper[ex_addr[0]];
                                r_nxt.ready = 1'b0;
                                r_nxt.busy_cnt = 20'h00000;
                                r_nxt.state = ST_NV_BUSY;
                            end
                        end
                        CMD_NV_WRITE: begin
                            if (ex_ok & s_wpn) begin
                                r_nxt.nv[ex_addr[0]] = ex_data;
                                r_nxt.ready = 1'b0;
                                r_nxt.busy_cnt = 20'h00000;
                                r_nxt.state = ST_NV_BUSY;
                            end
                        end
                        CMD_RECALL_ALL: begin
                            if (ex_addr == ADDR_RECALL_ALL) begin
                                r_nxt.wiper = r_r.nv;
                            end
                        end
                        CMD_READ_NV: begin
                            r_nxt.shift[DATA_MSB:DATA_LSB] = ex_ok ? r_r.nv[ex_addr[0]] : VAL_ZERO;
                        end
                        CMD_READ_WIPER: begin
                            r_nxt.shift[DATA_MSB:DATA_LSB] = ex_ok ? r_r.wiper[ex_addr[0]] : VAL_ZERO;
                        end
                        CMD_LOAD_WIPER: begin
                            if (ex_ok) begin
                                r_nxt.wiper[ex_addr[0]] = ex_data;
                            end
                        end
                        default: begin
                            for (int i = 0; i < CH_NUM; i++) begin
                                if (ex_cmd[0] | (ex_ok & (ex_addr == ADDR_W'(i)))) begin
                                    r_nxt.wiper[i] = step_val[i];
                                end
                            end
                        end
                    endcase
                end
            end
            ST_NV_BUSY: begin
                r_nxt.sdo_bit = 1'b1;
                if (r_r.busy_cnt == NV_CNT_W'(NV_CYCLES - 1)) begin
                    r_nxt.ready = 1'b1;
                    r_nxt.state = ST_IDLE;
                end else begin
                    r_nxt.busy_cnt = NV_CNT_W'(r_r.busy_cnt + 20'h00001);
                end
            end
            default: begin
                r_nxt.state = ST_RECALL;
            end
        endcase
    end

    // =========================================================
    // State register
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            r_r <= REGS_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // =========================================================
    // Outputs
    // Open drain: the pin only ever pulls low
    assign SERIAL_OUT_PIN_O = 1'b0;
    assign SERIAL_OUT_PIN_OE_N = s_csn | r_r.sdo_bit;
    assign READY = r_r.ready;
    assign WIPER0_SETTING = r_r.wiper[0];
    assign WIPER1_SETTING = r_r.wiper[1];
endmodule : dpscu_top

// >>> dpscu_wiper_step.sv
// Next wiper value for the rotate, shift, increment and decrement commands
`timescale 1ns/100ps
module dpscu_wiper_step
    import dpscu_pkg::*;
(
    input dpscu_cmd_t cmd,
    input wire logic [VAL_W-1:0] value,
    output logic [VAL_W-1:0] next_value
);
    // Data field plays no part here, only the present value
    always_comb begin
        case (cmd)
            CMD_ROR_ONE, CMD_ROR_ALL: begin
                next_value = {value[0], value[VAL_W-1:1]};
            end
            CMD_DEC_ONE, CMD_DEC_ALL: begin
                next_value = (value == VAL_ZERO) ? VAL_ZERO : VAL_W'(value - 10'h001);
            end
            CMD_SHL_ONE, CMD_SHL_ALL: begin
                next_value = value[VAL_W-1] ? VAL_ONES : {value[VAL_W-2:0], 1'b0};
            end
            CMD_INC_ONE, CMD_INC_ALL: begin
                next_value = (value == VAL_ONES) ? VAL_ONES : VAL_W'(value + 10'h001);
            end
            default: begin
                next_value = value;
            end
        endcase
    end
endmodule : dpscu_wiper_step
